// [hdl/hsw_consts.vh]
`ifndef HSW_CONSTS_VH
`define HSW_CONSTS_VH
// byte offset of the control/status byte (bits 23:16 of dword 0xe4)
`define HSW_CSR_OFFSET 8'he6
// dword holding the byte: it sits in lane 2 of this word
`define HSW_CSR_WORD 8'he4
// byte offset of the pin status register
`define HSW_PIN_OFFSET 8'he8
`define HSW_HIDE_ARM_BIT 16
`define HSW_ENUM_MASK_BIT 17
`define HSW_PEND_BIT 18
`define HSW_LED_BIT 19
`define HSW_PI_LO_BIT 20
`define HSW_PI_HI_BIT 21
`define HSW_EXT_BIT 22
`define HSW_INS_BIT 23
`define HSW_PI_CODE 2'h1
`define HSW_HIDE_ARM_RST 1'h0
`define HSW_ENUM_MASK_RST 1'h0
`define HSW_LED_RST 1'h0
`define HSW_EXT_RST 1'h0
`define HSW_INS_RST 1'h0
`define HSW_SYNC_STAGES 3
`endif

// [hdl/hsw_sync.v]
`timescale 1ns/100ps
// three-stage pin synchroniser; output changes once stages two and three agree
module hsw_sync (
   input wire clk,
   input wire rst_n,
   input wire din,
   output reg dout
);
   reg [2:0] sh_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= 3'h0;
         dout <= 1'b0;
      end else begin
         sh_q <= {sh_q[1:0], din};
         if (sh_q[1] == sh_q[2])
            dout <= sh_q[2];
      end
   end
endmodule // hsw_sync

// [hdl/hsw_ctrl.v]
`timescale 1ns/100ps
`include "hsw_consts.vh"
// Functional notes
// - while hide_arm is 1 the bridge answers no PCI transaction.
// - set hide_arm after PCI reset release with ejector handle open.
// - clear hide_arm when entering the insertion state.
// - enum_mask resets 0; 1 blocks enumeration output, 0 allows it.
// - pending_ins_ext is read-only and always reads 0.
// - led_control resets 0; 1 lights the LED, 0 leaves it dark.
// - prog_interface_code is read-only and reads binary 01.
// - extraction_flag set before removal; resets 0; write 1 clears.
// - extraction_flag set asserts enumeration_out_n low.
// - insertion_flag set only after handle closed and PCI reset released.
// - insertion_flag resets 0; write 1 clears, write 0 no effect.
// - insertion_flag set asserts enumeration_out_n low.
module hsw_ctrl (
   input wire CORE_CLK,
   input wire RESET_N,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   output reg WB_ERR_O,
   input wire PCI_RST_N,
   input wire HANDLE_OPEN,
   output reg ENUMERATION_OUT_N,
   output reg LED_OUT,
   output reg HIDE_OUT
);
   // hot-swap states
   localparam [3:0] ST_RESET = 4'h1;
   localparam [3:0] ST_INS = 4'h2;
   localparam [3:0] ST_RUN = 4'h4;
   localparam [3:0] ST_EXT = 4'h8;

   wire pci_rst_n_s;
   wire handle_open_s;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg hide_arm_q;
   reg enum_mask_q;
   reg led_control_q;
   reg extraction_flag_q;
   reg insertion_flag_q;
   reg pci_rst_n_prev_q;
   reg [31:0] rd_d;
   reg hit_csr;
   reg hit_pin;

   hsw_sync u_sync_rst (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .din(PCI_RST_N),
      .dout(pci_rst_n_s)
   );

   hsw_sync u_sync_handle (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .din(HANDLE_OPEN),
      .dout(handle_open_s)
   );

   function word_hit;
      input [7:0] adr;
      input [7:0] base;
      begin
         word_hit = (adr[7:2] == base[7:2]);
      end
   endfunction

   wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
   wire wr_csr = req & WB_WE_I & hit_csr & WB_SEL_I[2];
   wire rst_release = pci_rst_n_s & ~pci_rst_n_prev_q;
   wire clr_ext = wr_csr & WB_DAT_I[`HSW_EXT_BIT];
   wire clr_ins = wr_csr & WB_DAT_I[`HSW_INS_BIT];

   always @* begin
      hit_csr = word_hit(WB_ADR_I, `HSW_CSR_WORD);
      hit_pin = word_hit(WB_ADR_I, `HSW_PIN_OFFSET);
   end

   // insertion on release with handle closed, extraction when handle opens
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RESET: begin
            if (rst_release && !handle_open_s)
               state_d = ST_INS;
         end
         ST_INS: begin
            if (handle_open_s)
               state_d = ST_EXT;
            else if (!insertion_flag_q)
               state_d = ST_RUN;
         end
         ST_RUN: begin
            if (handle_open_s)
               state_d = ST_EXT;
         end
         ST_EXT: begin
            if (!handle_open_s && !extraction_flag_q)
               state_d = ST_INS;
         end
         default: state_d = ST_RESET;
      endcase
      if (!pci_rst_n_s)
         state_d = ST_RESET;
   end

   always @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q <= ST_RESET;
         pci_rst_n_prev_q <= 1'b0;
         hide_arm_q <= `HSW_HIDE_ARM_RST;
         enum_mask_q <= `HSW_ENUM_MASK_RST;
         led_control_q <= `HSW_LED_RST;
         extraction_flag_q <= `HSW_EXT_RST;
         insertion_flag_q <= `HSW_INS_RST;
      end else begin
         state_q <= state_d;
         pci_rst_n_prev_q <= pci_rst_n_s;
         // hardware set wins over software write
         if (rst_release && handle_open_s)
            hide_arm_q <= 1'b1;
         else if (state_d == ST_INS && state_q != ST_INS)
            hide_arm_q <= 1'b0;
         else if (wr_csr)
            hide_arm_q <= WB_DAT_I[`HSW_HIDE_ARM_BIT];
         if (wr_csr) begin
            enum_mask_q <= WB_DAT_I[`HSW_ENUM_MASK_BIT];
            led_control_q <= WB_DAT_I[`HSW_LED_BIT];
         end
         if (state_d == ST_EXT && state_q != ST_EXT)
            extraction_flag_q <= 1'b1;
         else if (clr_ext)
            extraction_flag_q <= 1'b0;
         if (state_d == ST_INS && state_q == ST_RESET)
            insertion_flag_q <= 1'b1;
         else if (clr_ins)
            insertion_flag_q <= 1'b0;
      end
   end

   always @* begin
      rd_d = 32'h0;
      if (hit_csr) begin
         rd_d[`HSW_HIDE_ARM_BIT] = hide_arm_q;
         rd_d[`HSW_ENUM_MASK_BIT] = enum_mask_q;
         rd_d[`HSW_PEND_BIT] = 1'b0;
         rd_d[`HSW_LED_BIT] = led_control_q;
         rd_d[`HSW_PI_HI_BIT:`HSW_PI_LO_BIT] = `HSW_PI_CODE;
         rd_d[`HSW_EXT_BIT] = extraction_flag_q;
         rd_d[`HSW_INS_BIT] = insertion_flag_q;
      end else if (hit_pin) begin
         rd_d[3:0] = state_q;
         rd_d[4] = handle_open_s;
         rd_d[5] = pci_rst_n_s;
      end
   end

   // one-wait-state slave; unmapped address answers with err
   always @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         WB_ACK_O <= 1'b0;
         WB_ERR_O <= 1'b0;
         WB_DAT_O <= 32'h0;
         ENUMERATION_OUT_N <= 1'b1;
         LED_OUT <= 1'b0;
         HIDE_OUT <= 1'b0;
      end else begin
         WB_ACK_O <= req & (hit_csr | hit_pin);
         WB_ERR_O <= req & ~(hit_csr | hit_pin);
         if (req && !WB_WE_I)
            WB_DAT_O <= rd_d;
         else
            WB_DAT_O <= 32'h0;
         ENUMERATION_OUT_N <= ~((extraction_flag_q | insertion_flag_q) & ~enum_mask_q);
         LED_OUT <= led_control_q;
         HIDE_OUT <= hide_arm_q;
      end
   end
endmodule // hsw_ctrl

// [sim/hsw_pins.sv]
`timescale 1ns/100ps
// board side: pci reset pin and ejector switch, moved on the bench's command
module hsw_pins (
   input wire clk,
   input wire r,
   input wire o,
   output reg prst_n = 1'b0,
   output reg hopen = 1'b0
);
   always @(posedge clk) begin
      prst_n <= r;
      hopen <= o;
   end
endmodule // hsw_pins

// [sim/hsw_monitor.sv]
`timescale 1ns/100ps
module hsw_monitor (
   input wire CORE_CLK,
   input wire RESET_N,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [31:0] WB_DAT_O,
   input wire WB_ACK_O,
   input wire WB_ERR_O,
   input wire ENUMERATION_OUT_N,
   input wire LED_OUT,
   input wire HIDE_OUT
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   wire req = WB_CYC_I & WB_STB_I;
   wire hit = WB_ADR_I[7:2] == 6'h39 || WB_ADR_I[7:2] == 6'h3a;
   wire rd = WB_ACK_O & !WB_WE_I & (WB_ADR_I[7:2] == 6'h39);
   wire flg = (WB_DAT_O[22] | WB_DAT_O[23]) & !WB_DAT_O[17];
   ack_lat_a: assert property ($rose(req) |=> WB_ACK_O ^ WB_ERR_O) else $error("no answer");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("long ack");
   unmapped_err_a: assert property ($rose(req) && !hit |=> WB_ERR_O) else $error("no err");
   idle_data_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("stray data");
   fixed_bits_a: assert property (rd |-> WB_DAT_O[21:20] == 2'h1 && !WB_DAT_O[18]) else $error("fixed bits");
   led_bit_a: assert property (rd |-> WB_DAT_O[19] == LED_OUT) else $error("led bit");
   hide_bit_a: assert property (rd |-> WB_DAT_O[16] == HIDE_OUT) else $error("hide bit");
   enum_level_a: assert property (rd |-> ENUMERATION_OUT_N == !flg) else $error("enum");
   cover property (rd && !ENUMERATION_OUT_N);
   cover property (rd && HIDE_OUT);
   cover property ($rose(req) && !hit);
endmodule // hsw_monitor
bind hsw_ctrl hsw_monitor i_mon (.*);

// [sim/hsw_ctrl_tb.sv]
`timescale 1ns/100ps
module hsw_ctrl_tb;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg cs = 1'b0;
   reg we = 1'b0;
   reg r = 1'b0;
   reg o = 1'b0;
   reg [7:0] adr = 8'h0;
   reg [31:0] wd = 32'h0;
   reg [31:0] rd;
   reg er;
   wire [31:0] dat;
   wire ack, err, prst_n, hopen, enum_n, led, hide;
   integer bad_count = 0;
   integer checks_done = 0;
   hsw_pins i_hsw_pins (.clk(clk), .r(r), .o(o), .prst_n(prst_n), .hopen(hopen));
   hsw_ctrl i_hsw_ctrl (.CORE_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cs), .WB_STB_I(cs),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h4), .WB_DAT_I(wd), .WB_DAT_O(dat),
      .WB_ACK_O(ack), .WB_ERR_O(err), .PCI_RST_N(prst_n), .HANDLE_OPEN(hopen),
      .ENUMERATION_OUT_N(enum_n), .LED_OUT(led), .HIDE_OUT(hide));
   initial begin
      forever #20 clk = ~clk;
   end
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks_done, bad_count);
         if (bad_count == 0 && checks_done > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         checks_done = checks_done + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   // one classic cycle; hold until ack or err is seen at an edge
   task acc(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk);
         cs <= 1'b1;
         we <= w;
         adr <= a;
         wd <= d;
         n = 0;
         @(posedge clk);
         while (ack !== 1'b1 && err !== 1'b1 && n < 20) begin
            @(posedge clk);
            n = n + 1;
         end
         rd = dat;
         er = err;
         cs <= 1'b0;
         we <= 1'b0;
         if (n == 20) chk(n, 0);
      end
   endtask
   task wr(input [7:0] b);
      acc(1'b1, 8'he6, {8'h0, b, 16'h0});
   endtask
   // let pins pass the synchroniser, then read the byte and the enum pin
   task rdchk(input [7:0] e, input en);
      begin
         repeat (12) @(posedge clk);
         acc(1'b0, 8'he6, 32'h0);
         chk(rd[23:16], e);
         chk(enum_n, en);
         $display("step done at %0t", $time);
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(8'h10, 1'b1);
      r <= 1'b1;
      rdchk(8'h90, 1'b0);
      wr(8'h02);
      rdchk(8'h92, 1'b1);
      wr(8'h08);
      rdchk(8'h98, 1'b0);
      chk(led, 1);
      wr(8'h88);
      rdchk(8'h18, 1'b1);
      wr(8'h00);
      o <= 1'b1;
      rdchk(8'h50, 1'b0);
      chk(led, 0);
      wr(8'h40);
      rdchk(8'h10, 1'b1);
      r <= 1'b0;
      repeat (8) @(posedge clk);
      r <= 1'b1;
      rdchk(8'h11, 1'b1);
      chk(hide, 1);
      r <= 1'b0;
      o <= 1'b0;
      repeat (8) @(posedge clk);
      r <= 1'b1;
      rdchk(8'h90, 1'b0);
      chk(hide, 0);
      acc(1'b0, 8'h10, 32'h0);
      chk(er, 1);
      print_verdict;
   end
   initial begin
      #100000;
      bad_count = bad_count + 1;
      print_verdict;
   end
endmodule // hsw_ctrl_tb
